// *** logic/eiw_detect.sv ***
// Edge and level detector for one synchronised external input.
// Assumes pin_sync is already on clk; hit is a one-cycle pulse per qualifying cycle.
`timescale 1ns/10ps
`default_nettype none

module eiw_detect (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Configuration and pin
  input  wire eiw_pkg::eiw_cfg_s cfg,
  input  wire logic             pin_sync,
  // Detection
  output var  logic             hit
);

  logic             prev_r;
  logic             prev_nxt;
  logic             rise;
  logic             fall;
  eiw_pkg::eiw_mode_e mode;

  always_comb begin
    prev_nxt = pin_sync;
  end

  // Reset low so a pin already high after reset is seen as a rising edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  always_comb begin
    mode = eiw_pkg::decode_mode(cfg.detect_sel); // R9 R10
    rise = pin_sync & ~prev_r;
    fall = ~pin_sync & prev_r;
    hit  = 1'b0;
    if (cfg.wake_en) begin // R11
      case (mode)
        eiw_pkg::MODE_RISE: hit = rise;
        eiw_pkg::MODE_FALL: hit = fall;
        eiw_pkg::MODE_BOTH: hit = rise | fall;
        eiw_pkg::MODE_HIGH: hit = pin_sync;
        eiw_pkg::MODE_LOW:  hit = ~pin_sync;
        default:            hit = 1'b0;
      endcase
    end
  end

endmodule : eiw_detect

`default_nettype wire

// *** logic/eiw_pkg.sv ***
// Shared constants and types for the upper external interrupt wake configuration block.
// Assumes a 16-bit register port with byte addresses; no other shared state.
`default_nettype none

package eiw_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int NUM_IN = 4;

  // Register byte addresses
  localparam logic [11:0] ADDR_CONFIG_UPPER = 12'hA24;
  localparam logic [11:0] ADDR_FLAG_CLEAR   = 12'hA30;
  localparam logic [11:0] ADDR_FLAG_STATE   = 12'hA40;
  localparam logic [11:0] ADDR_IRQ_STATUS   = 12'hA44;
  localparam logic [11:0] ADDR_IRQ_MASK     = 12'hA48;

  // Reset values
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [3:0]  FLAGS_RESET  = 4'h0;
  localparam logic [3:0]  MASK_RESET   = 4'h0;

  // Field positions inside the clear register: inputs 4..7 at bits 4..7
  localparam int CLEAR_LSB = 4;

  // Raw mode codes
  localparam logic [2:0] CODE_RISE      = 3'h0;
  localparam logic [2:0] CODE_FALL      = 3'h1;
  localparam logic [2:0] CODE_BOTH      = 3'h2;
  localparam logic [2:0] CODE_HIGH      = 3'h3;
  localparam logic [2:0] CODE_LOW       = 3'h4;
  localparam logic [2:0] CODE_FALL_ALT  = 3'h5;
  localparam logic [2:0] CODE_BOTH_ALT  = 3'h6;
  localparam logic [2:0] CODE_HIGH_ALT  = 3'h7;

  typedef enum logic [2:0] {
    MODE_RISE,
    MODE_FALL,
    MODE_BOTH,
    MODE_HIGH,
    MODE_LOW
  } eiw_mode_e;

  // One nibble of the configuration register: enable over 3-bit selector
  typedef struct packed {
    logic       wake_en;
    logic [2:0] detect_sel;
  } eiw_cfg_s;

  typedef eiw_cfg_s [3:0] eiw_cfg_t;

  // Aliased codes fold onto their base modes
  function automatic eiw_mode_e decode_mode(input logic [2:0] code);
    eiw_mode_e m;
    m = MODE_RISE;
    case (code)
      CODE_RISE:     m = MODE_RISE;
      CODE_FALL:     m = MODE_FALL;
      CODE_BOTH:     m = MODE_BOTH;
      CODE_HIGH:     m = MODE_HIGH;
      CODE_LOW:      m = MODE_LOW;
      CODE_FALL_ALT: m = MODE_FALL;
      CODE_BOTH_ALT: m = MODE_BOTH;
      CODE_HIGH_ALT: m = MODE_HIGH;
      default:       m = MODE_RISE;
    endcase
    return m;
  endfunction : decode_mode

endpackage : eiw_pkg

`default_nettype wire

// *** logic/eiw_sync2.sv ***
// Two-flop synchroniser for a vector of asynchronous pin levels.
// Assumes pins are unrelated to clk; each bit is synchronised on its own.
`timescale 1ns/10ps
`default_nettype none

module eiw_sync2 #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule : eiw_sync2

`default_nettype wire

// *** logic/eiw_top.sv ***
// Upper external interrupt wake configuration: inputs on general-purpose pins 4 to 7.
// Assumes a single-cycle register port with read data one cycle later, and asynchronous pins.
//
// Contract
// R1: Bit 15 of the configuration register enables input 7 as wake source.
// R2: Bits 14 to 12 select the detection mode of input 7.
// R3: Bit 11 enables input 6 as wake source.
// R4: Bits 10 to 8 select the detection mode of input 6.
// R5: Bit 7 enables input 5 as wake source.
// R6: Bits 6 to 4 select the detection mode of input 5.
// R7: Bit 3 enables input 4 as wake source.
// R8: Bits 2 to 0 select the detection mode of input 4.
// R9: Codes 000 rise, 001 fall, 010 either edge, 011 high, 100 low.
// R10: Codes 101, 110, 111 alias fall, either edge and high.
// R11: Enable bit 0 disables its input, 1 enables it.
// R12: Software sets wake enables before putting the device into hibernate.
// R13: Configuration register resets to zero: all disabled, rising edge selected.
// R14: Writing 1 to a clear bit drops that flag; bit self-clears.
// R15: An enabled input meeting its condition latches a flag driving wake request.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module eiw_top #(
  parameter int NUM_IN = eiw_pkg::NUM_IN
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // Register port
  input  wire logic [eiw_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [eiw_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output var  logic [eiw_pkg::DATA_W-1:0] reg_rdata,
  // External pins
  input  wire logic                       gp_pin_4,
  input  wire logic                       gp_pin_5,
  input  wire logic                       gp_pin_6,
  input  wire logic                       gp_pin_7,
  // Requests
  output var  logic                       wake_req,
  output var  logic                       irq
);

  // Configuration register as four packed nibbles; nibble 0 is input 4
  eiw_pkg::eiw_cfg_t            cfg_r;
  eiw_pkg::eiw_cfg_t            cfg_nxt;
  logic [NUM_IN-1:0]            flag_r;
  logic [NUM_IN-1:0]            flag_nxt;
  logic [NUM_IN-1:0]            status_r;
  logic [NUM_IN-1:0]            status_nxt;
  logic [NUM_IN-1:0]            mask_r;
  logic [NUM_IN-1:0]            mask_nxt;
  logic [eiw_pkg::DATA_W-1:0]   rdata_r;
  logic [eiw_pkg::DATA_W-1:0]   rdata_nxt;
  logic                         wake_r;
  logic                         wake_nxt;
  logic                         irq_r;
  logic                         irq_nxt;

  logic [NUM_IN-1:0]            pin_async;
  logic [NUM_IN-1:0]            pin_sync;
  logic [NUM_IN-1:0]            hit;
  logic [NUM_IN-1:0]            clear_req;
  logic                         wr_cfg;
  logic                         wr_clear;
  logic                         wr_mask;
  logic                         rd_status;

  assign pin_async = {gp_pin_7, gp_pin_6, gp_pin_5, gp_pin_4};

  eiw_sync2 #(
    .WIDTH (NUM_IN)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (pin_async),
    .sync_out (pin_sync)
  );

  // Nibble i carries enable at bit 4i+3 and selector at 4i+2..4i: R1 to R8 fall out of this layout
  for (genvar i = 0; i < NUM_IN; i++) begin : g_det
    eiw_detect u_det (
      .clk      (clk),
      .rst      (rst),
      .cfg      (cfg_r[i]), // R1 R2 R3 R4 R5 R6 R7 R8
      .pin_sync (pin_sync[i]),
      .hit      (hit[i])
    );
  end

  // Address decode
  always_comb begin
    wr_cfg    = 1'b0;
    wr_clear  = 1'b0;
    wr_mask   = 1'b0;
    rd_status = 1'b0;
    if (reg_wr && reg_addr == eiw_pkg::ADDR_CONFIG_UPPER) begin
      wr_cfg = 1'b1;
    end else if (reg_wr && reg_addr == eiw_pkg::ADDR_FLAG_CLEAR) begin
      wr_clear = 1'b1;
    end else if (reg_wr && reg_addr == eiw_pkg::ADDR_IRQ_MASK) begin
      wr_mask = 1'b1;
    end else if (reg_rd && reg_addr == eiw_pkg::ADDR_IRQ_STATUS) begin
      rd_status = 1'b1;
    end
  end

  // Clear bits act only on the write cycle, so the clear register always reads zero
  assign clear_req = wr_clear ? reg_wdata[eiw_pkg::CLEAR_LSB +: NUM_IN] : '0; // R14

  // Register next values
  always_comb begin
    cfg_nxt    = cfg_r;
    mask_nxt   = mask_r;
    if (wr_cfg) begin
      cfg_nxt = eiw_pkg::eiw_cfg_t'(reg_wdata); // R1 R2 R3 R4 R5 R6 R7 R8
    end
    if (wr_mask) begin
      mask_nxt = reg_wdata[NUM_IN-1:0];
    end
    // A detection in the clearing cycle survives the clear
    flag_nxt   = (flag_r & ~clear_req) | hit; // R15 R14
    status_nxt = (status_r & ~(rd_status ? {NUM_IN{1'b1}} : '0)) | hit;
    wake_nxt   = |flag_nxt; // R15
    irq_nxt    = |(status_nxt & mask_nxt);
  end

  // Read data, valid only in the cycle after the read strobe
  always_comb begin
    rdata_nxt = '0;
    if (reg_rd) begin
      if (reg_addr == eiw_pkg::ADDR_CONFIG_UPPER) begin
        rdata_nxt = eiw_pkg::DATA_W'(cfg_r);
      end else if (reg_addr == eiw_pkg::ADDR_FLAG_STATE) begin
        rdata_nxt = eiw_pkg::DATA_W'(flag_r);
      end else if (reg_addr == eiw_pkg::ADDR_IRQ_STATUS) begin
        rdata_nxt = eiw_pkg::DATA_W'(status_r);
      end else if (reg_addr == eiw_pkg::ADDR_IRQ_MASK) begin
        rdata_nxt = eiw_pkg::DATA_W'(mask_r);
      end else begin
        rdata_nxt = '0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_r    <= eiw_pkg::CONFIG_RESET; // R13
      flag_r   <= eiw_pkg::FLAGS_RESET;
      status_r <= eiw_pkg::FLAGS_RESET;
      mask_r   <= eiw_pkg::MASK_RESET;
      rdata_r  <= '0;
      wake_r   <= 1'b0;
      irq_r    <= 1'b0;
    end else begin
      cfg_r    <= cfg_nxt;
      flag_r   <= flag_nxt;
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
      rdata_r  <= rdata_nxt;
      wake_r   <= wake_nxt;
      irq_r    <= irq_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign wake_req  = wake_r;
  assign irq       = irq_r;

endmodule : eiw_top

`default_nettype wire

// *** testbench/eiw_assertions.sv ***
// Port checks for eiw_top.
// Assumes a bind to eiw_top; the config word is shadowed from observed writes.
`timescale 1ns/10ps
`default_nettype none
module eiw_top_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Pins and requests
  input wire logic        gp_pin_4,
  input wire logic        gp_pin_6,
  input wire logic        wake_req,
  input wire logic        irq
);
  logic [15:0] cfg_r;
  logic [2:0]  age_r;
  logic        settled;
  // Age gate keeps hits still in flight from an older config out of the pin checks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_r <= 16'h0000;
      age_r <= 3'h0;
    end else if (reg_wr && reg_addr == eiw_pkg::ADDR_CONFIG_UPPER) begin
      cfg_r <= reg_wdata;
      age_r <= 3'h0;
    end else if (age_r != 3'h7) begin
      age_r <= age_r + 3'h1;
    end
  end
  assign settled = age_r == 3'h7;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_cfg_rd;
    reg_rd && reg_addr == eiw_pkg::ADDR_CONFIG_UPPER;
  endsequence
  sequence s_high6;
    (settled && cfg_r[11] && cfg_r[9:8] == 2'h3 && gp_pin_6) [*4];
  endsequence
  chk_cfg_readback: assert property (s_cfg_rd |=> reg_rdata == cfg_r)
    else $error("config read differs");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside slot");
  chk_reset_quiet: assert property ($fell(rst) |-> !wake_req && !irq && reg_rdata == 16'h0000)
    else $error("outputs not quiet after reset");
  chk_dead_read: assert property (reg_rd && reg_addr == 12'hA28 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_mask_off: assert property (reg_wr && reg_addr == eiw_pkg::ADDR_IRQ_MASK && reg_wdata[3:0] == 4'h0
    |-> ##1 !irq) else $error("irq with mask clear");
  chk_off_quiet: assert property (reg_wr && reg_addr == eiw_pkg::ADDR_FLAG_CLEAR && reg_wdata[7:4] == 4'hF
    && settled && !(cfg_r[15] || cfg_r[11] || cfg_r[7] || cfg_r[3]) |-> ##2 !wake_req)
    else $error("wake with all inputs off");
  chk_rise_wake: assert property (settled && cfg_r[3] && cfg_r[2:0] == eiw_pkg::CODE_RISE
    && $rose(gp_pin_4) |-> ##[2:5] wake_req) else $error("rise on input 4 missed");
  chk_level_high: assert property (s_high6 |-> ##[1:3] wake_req)
    else $error("high level on input 6 missed");
endmodule : eiw_top_chk
bind eiw_top eiw_top_chk u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gp_pin_4(gp_pin_4), .gp_pin_6(gp_pin_6),
  .wake_req(wake_req), .irq(irq));
`default_nettype wire

// *** testbench/eiw_pin_drv.sv ***
// External source on the four general-purpose pins.
// Assumes requests change after a clock edge; pins follow one edge later.
`timescale 1ns/10ps
`default_nettype none
module eiw_pin_drv (
  // Clock
  input  wire logic       clk,
  // Requested and driven levels
  input  wire logic [3:0] want,
  output var  logic [3:0] pins
);
  // No reset: an outside source keeps its level while the device resets
  always_ff @(posedge clk) pins <= want;
endmodule : eiw_pin_drv
`default_nettype wire

// *** testbench/ext_irq_wake_config_upper_test.sv ***
// Self-checking bench for eiw_top: registers, detect modes, interrupt.
// Assumes eiw_pin_drv on the pins and eiw_top_chk bound to the design.
`timescale 1ns/10ps
`default_nettype none
module ext_irq_wake_config_upper_test;
  logic        clk, rst, reg_wr, reg_rd, wake_req, irq, p0, en, e;
  logic [11:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, got, cfg;
  logic [3:0]  want, pins;
  logic [2:0]  c;
  int          n_mismatch, num_checks, i;
  eiw_top u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gp_pin_4(pins[0]), .gp_pin_5(pins[1]), .gp_pin_6(pins[2]),
    .gp_pin_7(pins[3]), .wake_req(wake_req), .irq(irq));
  eiw_pin_drv u_pins (.clk(clk), .want(want), .pins(pins));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    num_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [15:0] g);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 g = reg_rdata;
  endtask : rd
  function automatic logic hit(input logic [2:0] m, input logic a, input logic b);
    case (m)
      3'h0: return !a && b;
      3'h1, 3'h5: return a && !b;
      3'h2, 3'h6: return a != b;
      3'h3, 3'h7: return b;
      default: return !b;
    endcase
  endfunction : hit
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'h4, 28'h0};
    n_mismatch = 0;
    num_checks = 0;
    void'($urandom(32'hDC980A58));
    want = 4'($urandom);
    tick(10);
    rst <= 1'b0;
    rd(eiw_pkg::ADDR_CONFIG_UPPER, got); chk(got, eiw_pkg::CONFIG_RESET);
    rd(eiw_pkg::ADDR_IRQ_MASK, got); chk(got, 16'h0000);
    rd(12'hA28, got); chk(got, 16'h0000);
    rd(eiw_pkg::ADDR_FLAG_CLEAR, got); chk(got, 16'h0000);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      cfg = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
      wr(eiw_pkg::ADDR_CONFIG_UPPER, cfg);
      rd(eiw_pkg::ADDR_CONFIG_UPPER, got); chk(got, cfg);
    end
    tick(1);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    rd(eiw_pkg::ADDR_CONFIG_UPPER, got); chk(got, eiw_pkg::CONFIG_RESET);
    $display("test config done");
    // Second pass runs every code with the opposite pin transition
    for (int p = 0; p < 2; p++) for (int k = 0; k < 9; k++) begin
      i = (k * 2 + k / 4) % 4;
      c = 3'(k);
      en = k < 8;
      p0 = 1'(p);
      want[i] <= p0;
      wr(eiw_pkg::ADDR_CONFIG_UPPER, 16'({en, c}) << (4 * i));
      tick(8);
      wr(eiw_pkg::ADDR_FLAG_CLEAR, 16'h00F0);
      want[i] <= ~p0;
      e = en & (hit(c, p0, p0) | hit(c, p0, ~p0));
      tick(8);
      #1 chk({15'h0, wake_req}, {15'h0, e});
      rd(eiw_pkg::ADDR_FLAG_STATE, got); chk(got, 16'(e) << i);
    end
    $display("test modes done");
    wr(eiw_pkg::ADDR_CONFIG_UPPER, 16'h000A);
    wr(eiw_pkg::ADDR_IRQ_MASK, 16'h0001);
    rd(eiw_pkg::ADDR_IRQ_MASK, got); chk(got, 16'h0001);
    tick(8);
    rd(eiw_pkg::ADDR_IRQ_STATUS, got);
    tick(1);
    #1 chk({15'h0, irq}, 16'h0000);
    tick(1);
    want[0] <= ~want[0];
    tick(8);
    #1 chk({15'h0, irq}, 16'h0001);
    rd(eiw_pkg::ADDR_IRQ_STATUS, got); chk(got, 16'h0001);
    tick(1);
    #1 chk({15'h0, irq}, 16'h0000);
    wr(eiw_pkg::ADDR_IRQ_MASK, 16'h0000);
    want[0] <= ~want[0];
    tick(8);
    #1 chk({15'h0, irq}, 16'h0000);
    rd(eiw_pkg::ADDR_IRQ_STATUS, got); chk(got, 16'h0001);
    $display("test irq done");
    results();
  end
endmodule : ext_irq_wake_config_upper_test
`default_nettype wire
